// ---- src/gtu_top.sv ----
// Top of the general timer unit with its Wishbone register slave.
//
// Overview of operation
// - Sync bits stay set after synchronising.
// - Properties register reads zero, narrow timer.
// - Daisy chain works in one-shot, periodic.
// - PWM timer ignores wait-on-trigger, starts.
// - Waiting after PWM predecessor never starts.
// - No sync if RTC or edge-count selected.
// - Match or prescale write steps counter if RTC or edge-count.
// - Edge-time up, load all ones breaks prescaler.
// - Edge-count up needs one extra edge.
`timescale 1ns/10ps
module gtu_top
    import gtu_pkg::*;
(
    // Clock and reset.
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    // Wishbone classic slave.
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADDR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // Input edge pins, one per timer.
    input  wire logic [NUM_TIMERS-1:0] edge_pin_i,
    // Interrupt.
    output logic                       irq_o
);

    // ------------------------------------------------------------------
    // Types and storage
    // ------------------------------------------------------------------
    localparam int EV_W = 2 * NUM_TIMERS;   // Timeout and match per timer.

    logic [NUM_TIMERS-1:0] sync_r;          // Timer sync register.
    logic [NUM_TIMERS-1:0] sync_pulse_r;    // Sync request issued to the timers.
    logic [EV_W-1:0]       istat_r;         // Sticky interrupt status.
    logic [EV_W-1:0]       imask_r;         // Interrupt mask.
    logic                  ack_r;           // Bus acknowledge.
    logic                  err_r;           // Bus error for unmapped addresses.
    logic [31:0]           rdat_r;          // Registered read data.
    logic [NUM_TIMERS-1:0] pin_s1_r;        // Edge pin synchroniser, first stage.
    logic [NUM_TIMERS-1:0] pin_s2_r;        // Edge pin synchroniser, second stage.
    logic [NUM_TIMERS-1:0] pin_s3_r;        // Delayed stage for edge detection.

    gtu_mode_t             t_mode  [NUM_TIMERS];
    logic [CNT_W-1:0]      t_load  [NUM_TIMERS];
    logic [CNT_W-1:0]      t_match [NUM_TIMERS];
    logic [7:0]            t_presc [NUM_TIMERS];
    logic [CNT_W-1:0]      t_count [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] t_tout;
    logic [NUM_TIMERS-1:0] t_mev;
    logic [NUM_TIMERS-1:0] t_trig;          // Trigger into each timer from its predecessor; tied low for timer 0.
    logic [NUM_TIMERS-1:0] t_sync_blk;      // Timer is RTC or edge count.
    logic [NUM_TIMERS-1:0] edge_ev;         // Rising edge seen on a synchronised pin.
    logic [31:0]           t_rdat  [NUM_TIMERS];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire       req      = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    wire       wr_req   = req && wb_we_i;
    wire       in_tmr   = (wb_adr_i >= TMR_BASE) &&
                          (wb_adr_i < TMR_BASE + TMR_STRIDE * 8'(NUM_TIMERS));
    wire [7:0] tmr_rel  = wb_adr_i - TMR_BASE;
    wire [1:0] tmr_idx  = tmr_rel[6:5];
    wire [4:0] tmr_ofs  = tmr_rel[4:0];
    wire       hit_sync = (wb_adr_i == OFS_SYNC);
    wire       hit_prop = (wb_adr_i == OFS_PROPS);
    wire       hit_ist  = (wb_adr_i == OFS_ISTAT);
    wire       hit_imk  = (wb_adr_i == OFS_IMASK);
    wire       hit_treg = in_tmr && (tmr_ofs == OFS_MODE || tmr_ofs == OFS_LOAD ||
                          tmr_ofs == OFS_MATCH || tmr_ofs == OFS_PRESC || tmr_ofs == OFS_COUNT);
    wire       mapped   = hit_sync || hit_prop || hit_ist || hit_imk || hit_treg;
    wire       lane0    = wb_sel_i[0];
    wire       lane1    = wb_sel_i[1];

    // Sync write: a set bit only takes effect on a zero-to-one change and
    // zeros merely clear, so software must clear before re-requesting.
    wire                  sync_we   = wr_req && hit_sync && lane0;
    wire [NUM_TIMERS-1:0] sync_new  = wb_dat_i[NUM_TIMERS-1:0];
    wire [NUM_TIMERS-1:0] sync_rise = sync_new & ~sync_r;
    // The whole request is dropped if any selected timer is RTC or edge count.
    wire                  sync_blk  = |(sync_rise & t_sync_blk);
    wire [NUM_TIMERS-1:0] sync_req  = (sync_we && !sync_blk) ? sync_rise : '0;

    // Status: a new event beats a simultaneous clear.
    wire [EV_W-1:0] ev_all  = {t_mev, t_tout};
    wire [EV_W-1:0] ist_clr = (wr_req && hit_ist && lane0) ? wb_dat_i[EV_W-1:0] : '0;
    wire [EV_W-1:0] ist_nxt = (istat_r & ~ist_clr) | ev_all;

    // Read multiplexer.
    wire [31:0] rd_mux = hit_sync ? {{(32-NUM_TIMERS){1'b0}}, sync_r} :
                         hit_prop ? PROPS_NARROW :
                         hit_ist  ? {{(32-EV_W){1'b0}}, istat_r} :
                         hit_imk  ? {{(32-EV_W){1'b0}}, imask_r} :
                         hit_treg ? t_rdat[tmr_idx] : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Per-timer channels and daisy chain
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
            gtu_wr_t wr_g;
            wire sel_g = wr_req && hit_treg && (tmr_idx == 2'(g)) && lane0 && lane1;
            assign wr_g.mode_we  = sel_g && (tmr_ofs == OFS_MODE);
            assign wr_g.load_we  = sel_g && (tmr_ofs == OFS_LOAD);
            assign wr_g.match_we = sel_g && (tmr_ofs == OFS_MATCH);
            assign wr_g.presc_we = sel_g && (tmr_ofs == OFS_PRESC);
            assign wr_g.data     = wb_dat_i[CNT_W-1:0];

            // Only one-shot and periodic predecessors drive the chain; a PWM
            // predecessor leaves its follower waiting forever.
            if (g == 0) begin : g_first
                assign t_trig[g] = 1'b0;
            end else begin : g_next
                assign t_trig[g] = t_tout[g-1] &&
                    (t_mode[g-1].fn == FN_ONESHOT || t_mode[g-1].fn == FN_PERIODIC);
            end

            assign t_sync_blk[g] = (t_mode[g].fn == FN_RTC) || (t_mode[g].fn == FN_ECOUNT);
            assign edge_ev[g]    = pin_s2_r[g] && !pin_s3_r[g];

            assign t_rdat[g] = (tmr_ofs == OFS_MODE)  ? {26'h0, 6'(t_mode[g])} :
                               (tmr_ofs == OFS_LOAD)  ? {16'h0, t_load[g]} :
                               (tmr_ofs == OFS_MATCH) ? {16'h0, t_match[g]} :
                               (tmr_ofs == OFS_PRESC) ? {24'h0, t_presc[g]} :
                                                        {16'h0, t_count[g]};

            gtu_timer u_timer (
                .sys_clk_i  (sys_clk_i),
                .rst_i      (rst_i),
                .wr_i       (wr_g),
                .sync_i     (sync_pulse_r[g]),
                .trig_i     (t_trig[g]),
                .edge_i     (edge_ev[g]),
                .mode_o     (t_mode[g]),
                .load_o     (t_load[g]),
                .match_o    (t_match[g]),
                .presc_o    (t_presc[g]),
                .count_o    (t_count[g]),
                .timeout_o  (t_tout[g]),
                .match_ev_o (t_mev[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Edge pin synchroniser; the second and third stages feed edge detection.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= edge_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // Sync register: bits stay as written, hardware never clears them.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_r       <= '0;
            sync_pulse_r <= '0;
        end else begin
            if (sync_we) begin
                sync_r <= sync_new;
            end
            sync_pulse_r <= sync_req;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            istat_r <= '0;
            imask_r <= '0;
        end else begin
            istat_r <= ist_nxt;
            if (wr_req && hit_imk && lane0) begin
                imask_r <= wb_dat_i[EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus answer: one wait state, ack or err then drop.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            err_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req && mapped;
            err_r  <= req && !mapped;
            rdat_r <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdat_r;
    assign irq_o    = |(istat_r & imask_r);

endmodule

// ---- src/gtu_pkg.sv ----
// Package of register offsets, field layouts and modes for the general timer unit.
package gtu_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_TIMERS = 4;             // Timers in the daisy chain.
    localparam int CNT_W      = 16;            // Counter width.
    localparam int ADDR_W     = 8;             // Byte address width.

    // ------------------------------------------------------------------
    // Register byte offsets (per-timer block at TMR_BASE + n*TMR_STRIDE)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_SYNC    = 8'h00; // Timer sync register.
    localparam logic [7:0] OFS_PROPS   = 8'h04; // Timer properties register.
    localparam logic [7:0] OFS_ISTAT   = 8'h08; // Interrupt status, write one to clear.
    localparam logic [7:0] OFS_IMASK   = 8'h0c; // Interrupt mask.
    localparam logic [7:0] TMR_BASE    = 8'h40; // First per-timer block.
    localparam logic [7:0] TMR_STRIDE  = 8'h20; // Size of one per-timer block.
    localparam logic [4:0] OFS_MODE    = 5'h00; // Timer mode register.
    localparam logic [4:0] OFS_LOAD    = 5'h04; // Timer interval load register.
    localparam logic [4:0] OFS_MATCH   = 5'h08; // Timer match register.
    localparam logic [4:0] OFS_PRESC   = 5'h0c; // Timer prescale register.
    localparam logic [4:0] OFS_COUNT   = 5'h10; // Current counter value, read only.

    // ------------------------------------------------------------------
    // Properties register value: the faulty silicon reads narrow.
    // ------------------------------------------------------------------
    localparam logic [31:0] PROPS_NARROW = 32'h0000_0000;
    localparam logic [31:0] PROPS_WIDE   = 32'h0000_0001; // Intended value, never returned.

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int MODE_FN_LSB  = 0;            // Function select, 3 bits.
    localparam int MODE_EN_BIT  = 3;            // Timer enable.
    localparam int MODE_UP_BIT  = 4;            // Count up when set.
    localparam int MODE_WOT_BIT = 5;            // Wait on trigger bit.
    localparam logic [5:0] MODE_MASK = 6'h3f;

    // Function encodings.
    localparam logic [2:0] FN_ONESHOT  = 3'h0;
    localparam logic [2:0] FN_PERIODIC = 3'h1;
    localparam logic [2:0] FN_PWM      = 3'h2;
    localparam logic [2:0] FN_RTC      = 3'h3;
    localparam logic [2:0] FN_ECOUNT   = 3'h4;
    localparam logic [2:0] FN_ETIME    = 3'h5;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
    localparam logic [7:0]       PRE_ZERO = 8'h00;
    localparam logic [7:0]       PRE_ONE  = 8'h01;

    // Decoded mode register of one timer.
    typedef struct packed {
        logic       wot;
        logic       up;
        logic       en;
        logic [2:0] fn;
    } gtu_mode_t;

    // Register write request to one timer.
    typedef struct packed {
        logic             mode_we;
        logic             load_we;
        logic             match_we;
        logic             presc_we;
        logic [CNT_W-1:0] data;
    } gtu_wr_t;

endpackage

// ---- src/gtu_timer.sv ----
// One general timer channel of the timer unit.
`timescale 1ns/10ps
module gtu_timer
    import gtu_pkg::*;
(
    // Clock and reset.
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    // Register access.
    input  wire gtu_wr_t          wr_i,
    input  wire logic             sync_i,
    // Chain and edge inputs.
    input  wire logic             trig_i,
    input  wire logic             edge_i,
    // State out.
    output gtu_mode_t             mode_o,
    output logic [CNT_W-1:0]      load_o,
    output logic [CNT_W-1:0]      match_o,
    output logic [7:0]            presc_o,
    output logic [CNT_W-1:0]      count_o,
    output logic                  timeout_o,
    output logic                  match_ev_o
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    gtu_mode_t        mode_r;      // Mode register.
    logic [CNT_W-1:0] load_r;      // Interval load register.
    logic [CNT_W-1:0] match_r;     // Match register.
    logic [7:0]       presc_r;     // Prescale register.
    logic [7:0]       pcnt_r;      // Prescaler counter.
    logic [CNT_W-1:0] cnt_r;       // Main counter.
    logic             run_r;       // Counting started (trigger seen or not needed).
    logic             armed_r;     // Edge-count match reached, next edge clears.

    logic [CNT_W-1:0] cnt_nxt;
    logic             run_nxt;
    logic             armed_nxt;
    logic [7:0]       pcnt_nxt;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire is_pwm    = (mode_r.fn == FN_PWM);
    wire is_rtc    = (mode_r.fn == FN_RTC);
    wire is_ecnt   = (mode_r.fn == FN_ECOUNT);
    wire is_etime  = (mode_r.fn == FN_ETIME);
    // A PWM timer never honours wait-on-trigger and starts at once.
    wire need_trig = mode_r.wot && !is_pwm;
    wire start_ok  = !need_trig || trig_i;
    // A sync restart only matters while the timer is running.
    wire do_sync   = sync_i && mode_r.en;
    // Match or prescale writes bump the counter in RTC and edge-count modes.
    wire bump      = mode_r.en && (is_rtc || is_ecnt) && (wr_i.match_we || wr_i.presc_we);
    // Prescaler: in edge-time up mode with load at all ones the tick is broken
    // and always fires, so the prescale value has no effect.
    wire pre_bad   = is_etime && mode_r.up && (load_r == CNT_MAX);
    wire pre_tick  = pre_bad || (pcnt_r == presc_r);
    // Counting event of the current function.
    wire src_ev    = (is_ecnt || is_etime) ? edge_i : pre_tick;
    wire cnt_top   = mode_r.up ? (cnt_r == load_r) : (cnt_r == CNT_ZERO);
    wire at_match  = (cnt_r == match_r);

    // ------------------------------------------------------------------
    // Next-state logic for counter and start control
    // ------------------------------------------------------------------
    always_comb begin
        cnt_nxt   = cnt_r;
        run_nxt   = run_r;
        armed_nxt = armed_r;
        pcnt_nxt  = pcnt_r;
        timeout_o = 1'b0;
        match_ev_o = 1'b0;
        if (!mode_r.en) begin
            // Disabled: stop and wait for a fresh start.
            run_nxt   = 1'b0;
            armed_nxt = 1'b0;
            pcnt_nxt  = PRE_ZERO;
        end else if (!run_r) begin
            if (start_ok) begin
                run_nxt = 1'b1;
                cnt_nxt = mode_r.up ? CNT_ZERO : load_r;
            end
        end else if (do_sync) begin
            // Synchronised restart of the counter.
            cnt_nxt  = mode_r.up ? CNT_ZERO : load_r;
            pcnt_nxt = PRE_ZERO;
        end else if (bump) begin
            cnt_nxt = mode_r.up ? cnt_r + CNT_ONE : cnt_r - CNT_ONE;
        end else begin
            if (!is_ecnt && !is_etime) begin
                pcnt_nxt = pre_tick ? PRE_ZERO : pcnt_r + PRE_ONE;
            end
            if (src_ev) begin
                if (is_ecnt && mode_r.up) begin
                    // Reaching match flags the event but holds the count;
                    // one extra edge is needed to return to zero.
                    if (armed_r) begin
                        cnt_nxt   = CNT_ZERO;
                        armed_nxt = 1'b0;
                    end else if (cnt_r + CNT_ONE == match_r) begin
                        cnt_nxt    = match_r;
                        armed_nxt  = 1'b1;
                        match_ev_o = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + CNT_ONE;
                    end
                end else if (cnt_top) begin
                    timeout_o = 1'b1;
                    cnt_nxt   = mode_r.up ? CNT_ZERO : load_r;
                    // One-shot stops after its timeout.
                    if (mode_r.fn == FN_ONESHOT) begin
                        run_nxt = 1'b0;
                    end
                end else begin
                    cnt_nxt    = mode_r.up ? cnt_r + CNT_ONE : cnt_r - CNT_ONE;
                    match_ev_o = at_match && is_ecnt;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes and state update
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r  <= '0;
            load_r  <= CNT_MAX;
            match_r <= CNT_MAX;
            presc_r <= PRE_ZERO;
        end else begin
            if (wr_i.mode_we)  mode_r  <= gtu_mode_t'(wr_i.data[5:0] & MODE_MASK);
            if (wr_i.load_we)  load_r  <= wr_i.data;
            if (wr_i.match_we) match_r <= wr_i.data;
            if (wr_i.presc_we) presc_r <= wr_i.data[7:0];
        end
    end

    // Counter state update.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r   <= CNT_ZERO;
            run_r   <= 1'b0;
            armed_r <= 1'b0;
            pcnt_r  <= PRE_ZERO;
        end else begin
            cnt_r   <= cnt_nxt;
            run_r   <= run_nxt;
            armed_r <= armed_nxt;
            pcnt_r  <= pcnt_nxt;
        end
    end

    assign mode_o  = mode_r;
    assign load_o  = load_r;
    assign match_o = match_r;
    assign presc_o = presc_r;
    assign count_o = cnt_r;

endmodule

// ---- verif/gtu_props.sv ----
// Bus-level checker for the timer unit register slave.
`timescale 1ns/10ps
module gtu_props
    import gtu_pkg::*;
(
    // Clock, reset and bus signals watched.
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              wb_err_o
);
    // -----------------------------------------------------------------
    // Sequences and properties
    // -----------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // A request is taken only while no answer is outstanding.
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_props_rd;
        s_take ##0 (!wb_we_i && wb_adr_i == OFS_PROPS);
    endsequence
    property p_answer;      s_take |=> (wb_ack_o || wb_err_o); endproperty
    property p_ack_pulse;   wb_ack_o |=> !wb_ack_o; endproperty
    property p_err_pulse;   wb_err_o |=> !wb_err_o; endproperty
    property p_one_answer;  !(wb_ack_o && wb_err_o); endproperty
    property p_idle_data;   !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    property p_no_spurious; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o; endproperty
    property p_props;       s_props_rd |=> wb_ack_o && wb_dat_o == PROPS_NARROW; endproperty
    // Offset 0x10 lies in the gap between global and timer registers.
    property p_unmapped;    s_take ##0 (wb_adr_i == 8'h10) |=> wb_err_o && !wb_ack_o; endproperty
    a_answer:      assert property (p_answer) else $error("No answer one cycle after request");
    a_ack_pulse:   assert property (p_ack_pulse) else $error("Ack held longer than one cycle");
    a_err_pulse:   assert property (p_err_pulse) else $error("Err held longer than one cycle");
    a_one_answer:  assert property (p_one_answer) else $error("Ack and err together");
    a_idle_data:   assert property (p_idle_data) else $error("Read data not zero outside ack");
    a_no_spurious: assert property (p_no_spurious) else $error("Answer without request");
    a_props:       assert property (p_props) else $error("Properties read not narrow");
    a_unmapped:    assert property (p_unmapped) else $error("Unmapped access not refused");
endmodule
bind gtu_top gtu_props gtu_props_inst (.sys_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o);

// ---- verif/gtu_top_tb.sv ----
// Self-checking testbench of the general timer unit.
`timescale 1ns/10ps
module gtu_top_tb
    import gtu_pkg::*;
;
    // -----------------------------------------------------------------
    // Stimulus and observed signals
    // -----------------------------------------------------------------
    logic                  sys_clk_i   = 1'b0;
    logic                  rst_i       = 1'b1;
    logic                  req         = 1'b0;  // Drives cyc and stb together.
    logic                  we          = 1'b0;
    logic [7:0]            adr         = 8'h00;
    logic [31:0]           wdat        = 32'h0;
    logic [NUM_TIMERS-1:0] edge_pin    = 4'h0;
    logic [31:0]           rdat, q, a, b;
    logic                  ack, err, irq, last_err;
    int                    mismatches  = 0;
    int                    checks_done = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    // All byte lanes are always enabled; narrow writes are not exercised.
    gtu_top gtu_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .edge_pin_i(edge_pin), .irq_o(irq));
    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One classic cycle; holds the request until ack or err is sampled high.
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
        req  <= 1'b1;
        we   <= w;
        adr  <= ad;
        wdat <= d;
        do @(posedge sys_clk_i); while (ack !== 1'b1 && err !== 1'b1);
        r = rdat;
        last_err = err;
        req <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    function automatic logic [7:0] ta(input int n, input logic [4:0] o);
        return TMR_BASE + TMR_STRIDE * 8'(n) + {3'h0, o};
    endfunction
    // Long enough pulse to cross the pin synchroniser.
    task automatic pulse(input int t);
        edge_pin[t] <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        edge_pin[t] <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
    endtask
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    // Properties read narrow, offset 0x10 is refused, sync bits stay as written.
    task automatic t_regs;
        wb(1'b0, OFS_PROPS, 32'h0, q);
        check(q, PROPS_NARROW);
        wb(1'b0, 8'h10, 32'h0, q);
        check({31'h0, last_err}, 32'h1);
        wb(1'b1, OFS_SYNC, 32'h1, q);
        wb(1'b0, OFS_SYNC, 32'h0, q);
        check(q, 32'h1);
        wb(1'b1, OFS_SYNC, 32'h0, q);
        wb(1'b0, OFS_SYNC, 32'h0, q);
        check(q, 32'h0);
    endtask
    // Edge count up on timer 0: write side effect, extra edge, interrupt path.
    task automatic t_edge;
        wb(1'b1, ta(0, OFS_MATCH), 32'h3, q);
        wb(1'b1, ta(0, OFS_MODE), 32'h1c, q);
        wb(1'b1, ta(0, OFS_PRESC), 32'h0, q);
        wb(1'b0, ta(0, OFS_COUNT), 32'h0, q);
        check(q, 32'h1);
        pulse(0);
        pulse(0);
        wb(1'b0, ta(0, OFS_COUNT), 32'h0, q);
        check(q, 32'h3);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, OFS_IMASK, 32'h10, q);
        check({31'h0, irq}, 32'h1);
        pulse(0);
        wb(1'b0, ta(0, OFS_COUNT), 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, OFS_ISTAT, 32'h10, q);
        check({31'h0, irq}, 32'h0);
    endtask
    // Edge count down on timer 3: a match write steps the count down.
    task automatic t_down;
        wb(1'b1, ta(3, OFS_MODE), 32'h0c, q);
        wb(1'b0, ta(3, OFS_COUNT), 32'h0, a);
        wb(1'b1, ta(3, OFS_MATCH), 32'h5, q);
        wb(1'b0, ta(3, OFS_COUNT), 32'h0, q);
        check(a, {16'h0, CNT_MAX});
        check(q, {16'h0, CNT_MAX - CNT_ONE});
    endtask
    // PWM timer 1 ignores wait-on-trigger and runs, one-shot timer 2 waits behind it.
    task automatic t_chain;
        wb(1'b1, ta(1, OFS_LOAD), 32'h4, q);
        wb(1'b1, ta(1, OFS_MODE), 32'h2a, q);
        wb(1'b1, ta(2, OFS_MODE), 32'h28, q);
        wb(1'b0, ta(1, OFS_COUNT), 32'h0, a);
        wb(1'b0, ta(2, OFS_COUNT), 32'h0, b);
        repeat (20) @(posedge sys_clk_i);
        wb(1'b0, ta(1, OFS_COUNT), 32'h0, q);
        check({31'h0, q !== a}, 32'h1);
        wb(1'b0, ta(2, OFS_COUNT), 32'h0, q);
        check(q, 32'h0);
    endtask
    // Periodic timer 1 starts timer 2; a sync is dropped while timer 0 counts edges.
    task automatic t_sync;
        wb(1'b1, ta(1, OFS_MODE), 32'h09, q);
        repeat (50) @(posedge sys_clk_i);
        wb(1'b0, ta(2, OFS_COUNT), 32'h0, a);
        check({31'h0, a[15:0] != CNT_ZERO}, 32'h1);
        wb(1'b1, OFS_SYNC, 32'h5, q);
        wb(1'b1, OFS_SYNC, 32'h0, q);
        wb(1'b0, ta(2, OFS_COUNT), 32'h0, b);
        check({31'h0, b < a}, 32'h1);
        wb(1'b1, OFS_SYNC, 32'h4, q);
        wb(1'b0, ta(2, OFS_COUNT), 32'h0, q);
        check({31'h0, q > b}, 32'h1);
    endtask
    // -----------------------------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        t_regs;
        t_edge;
        t_down;
        t_chain;
        t_sync;
        final_report;
    end
    // The tests need well under 2,000 cycles; this gives ample margin.
    initial begin
        #50000;
        mismatches++;
        final_report;
    end
endmodule
